/* File: core/a2q_consts.svh */
// offsets, field positions and reset values of the pulse-train block
// assumes a 32-bit classic wishbone slave with byte addressing
`ifndef A2Q_CONSTS_SVH
`define A2Q_CONSTS_SVH

// -------------------------------------------------------
// register byte offsets
// -------------------------------------------------------
`define A2Q_OFF_CTRL 8'h00
`define A2Q_OFF_STATUS 8'h04
`define A2Q_OFF_COUNT 8'h08
`define A2Q_OFF_SPACING 8'h0C
`define A2Q_OFF_INDEX 8'h10
`define A2Q_OFF_PUSH 8'h14
`define A2Q_OFF_PROGRESS 8'h18

// -------------------------------------------------------
// field positions
// -------------------------------------------------------
`define A2Q_CTRL_SETUP 0
`define A2Q_CTRL_START 1
`define A2Q_CTRL_FLUSH 2
`define A2Q_ST_BUSY 0
`define A2Q_ST_PEND 1
`define A2Q_ST_EMPTY 2
`define A2Q_ST_FULL 3
`define A2Q_ST_OVF 4
`define A2Q_ST_LEVEL_LSB 8
`define A2Q_PUSH_DIR 0
`define A2Q_PUSH_CROSS 1

// -------------------------------------------------------
// reset values and direction codes
// -------------------------------------------------------
`define A2Q_CTRL_RST 1'b0
`define A2Q_STEP_RST 16'h0000
`define A2Q_DIR_CW 1'b0
`define A2Q_DIR_CCW 1'b1
`define A2Q_SPACING_MIN 16'h0001

`endif

/* File: core/a2q_pkg.sv */
// types shared by the pulse-train block
// assumes a2q_consts.svh sits beside it on the include path
package a2q_pkg;

	// one queued pulse-train job
	typedef struct packed {
		logic dirCounter; // 1: B leads A
		logic crossZero; // index edges valid
		logic [15:0] stepCount; // internal step clocks
		logic [15:0] spacing; // logic clocks between steps
		logic [15:0] idxRise; // step number raising index
		logic [15:0] idxFall; // step number lowering index
	} a2q_job_t;

	// quadrature and index outputs
	typedef struct packed {
		logic encA;
		logic encB;
		logic encIdx;
	} a2q_enc_t;

	typedef enum logic [1:0] {
		A2Q_IDLE = 2'b01,
		A2Q_RUN = 2'b10
	} a2q_state_t;

endpackage

/* File: core/a2q_top.sv */
// absolute-to-quadrature pulse train generator with wishbone register access
// assumes one 200 MHz clock, async active-high reset, synchronous inputs
// Contract
// - jobs come from a pull fifo software fills: count, spacing, index edges, direction
// - quadrature outputs move on exactly the commanded number of step clocks
// - consecutive step clocks are spaced by the commanded logic-clock count
// - on zero crossing index rises at one step edge and falls at another
// - job direction selects whether A leads B or B leads A
// - a new train starts only after the previous one fully completes
// - no output pulses before setup is done after every reset
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "a2q_consts.svh"

module a2q_top import a2q_pkg::*; #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk, // 200 MHz logic clock
	input wire logic rst, // async reset, active high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // one-cycle ack
	output a2q_enc_t encOut, // emulated encoder A, B, index
	output logic trainBusy // a train is playing
);

	localparam int AW = $clog2(FIFO_DEPTH);

	// -------------------------------------------------------
	// storage
	// -------------------------------------------------------
	logic setupDone_r;
	logic startPend_r;
	logic overflow_r;
	logic [15:0] stageCount_r;
	logic [15:0] stageSpacing_r;
	logic [31:0] stageIndex_r;
	a2q_job_t fifoMem [FIFO_DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	a2q_state_t state_r;
	a2q_job_t job_r;
	logic [15:0] stepsDone_r;
	logic [15:0] waitCnt_r;
	logic [31:0] rdData_nxt;

	wire logic busAccess = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic busWrite = busAccess & wb_we_i;
	wire logic [AW:0] fifoLevel = wrPtr_r - rdPtr_r;
	wire logic fifoEmpty = (wrPtr_r == rdPtr_r);
	wire logic fifoFull = (fifoLevel == (AW + 1)'(FIFO_DEPTH));
	wire logic pushReq = busWrite & (wb_adr_i == `A2Q_OFF_PUSH) & wb_sel_i[0];
	wire logic ctrlWr = busWrite & (wb_adr_i == `A2Q_OFF_CTRL) & wb_sel_i[0];
	wire logic flushReq = ctrlWr & wb_dat_i[`A2Q_CTRL_FLUSH];
	wire logic startReq = ctrlWr & wb_dat_i[`A2Q_CTRL_START];
	// a job is launched only from idle, after setup, on a start request
	wire logic launch = (state_r == A2Q_IDLE) & setupDone_r & startPend_r & ~fifoEmpty;
	wire logic stepTick = (state_r == A2Q_RUN) & (waitCnt_r == 16'h0001)
		& (stepsDone_r != job_r.stepCount);
	wire logic [15:0] stepNum = stepsDone_r + 16'h0001;

	// byte-lane merge for the staging registers
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// -------------------------------------------------------
	// wishbone slave: one wait state, ack for every address
	// -------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busAccess;
			wb_dat_o <= busAccess & ~wb_we_i ? rdData_nxt : 32'h0000_0000;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdData_nxt = 32'h0000_0000;
		case (wb_adr_i)
			`A2Q_OFF_CTRL: begin
				rdData_nxt[`A2Q_CTRL_SETUP] = setupDone_r;
			end
			`A2Q_OFF_STATUS: begin
				rdData_nxt[`A2Q_ST_BUSY] = (state_r == A2Q_RUN);
				rdData_nxt[`A2Q_ST_PEND] = startPend_r;
				rdData_nxt[`A2Q_ST_EMPTY] = fifoEmpty;
				rdData_nxt[`A2Q_ST_FULL] = fifoFull;
				rdData_nxt[`A2Q_ST_OVF] = overflow_r;
				rdData_nxt[`A2Q_ST_LEVEL_LSB +: AW + 1] = fifoLevel;
			end
			`A2Q_OFF_COUNT: begin
				rdData_nxt[15:0] = stageCount_r;
			end
			`A2Q_OFF_SPACING: begin
				rdData_nxt[15:0] = stageSpacing_r;
			end
			`A2Q_OFF_INDEX: begin
				rdData_nxt = stageIndex_r;
			end
			`A2Q_OFF_PROGRESS: begin
				rdData_nxt[15:0] = stepsDone_r;
			end
			default: begin
				rdData_nxt = 32'h0000_0000;
			end
		endcase
	end

	// control: setup flag and start request held until a job launches
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			setupDone_r <= `A2Q_CTRL_RST;
			startPend_r <= `A2Q_CTRL_RST;
		end else begin
			if (ctrlWr) begin
				setupDone_r <= wb_dat_i[`A2Q_CTRL_SETUP];
			end
			// a start during a running train waits here, so set beats launch
			if (startReq) begin
				startPend_r <= 1'b1;
			end else if (launch) begin
				startPend_r <= 1'b0;
			end
		end
	end

	// staging words assembled before the push
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stageCount_r <= `A2Q_STEP_RST;
			stageSpacing_r <= `A2Q_SPACING_MIN;
			stageIndex_r <= 32'h0000_0000;
		end else if (busWrite) begin
			case (wb_adr_i)
				`A2Q_OFF_COUNT: begin
					stageCount_r <= 16'(laneMerge({16'h0000, stageCount_r}, wb_dat_i,
						wb_sel_i));
				end
				`A2Q_OFF_SPACING: begin
					stageSpacing_r <= 16'(laneMerge({16'h0000, stageSpacing_r}, wb_dat_i,
						wb_sel_i));
				end
				`A2Q_OFF_INDEX: begin
					stageIndex_r <= laneMerge(stageIndex_r, wb_dat_i, wb_sel_i);
				end
				default: begin
				end
			endcase
		end
	end

	// -------------------------------------------------------
	// pull fifo of jobs
	// -------------------------------------------------------
	always_ff @(posedge clk) begin
		if (pushReq & ~fifoFull) begin
			fifoMem[wrPtr_r[AW-1:0]] <= '{
				dirCounter: wb_dat_i[`A2Q_PUSH_DIR],
				crossZero: wb_dat_i[`A2Q_PUSH_CROSS],
				stepCount: stageCount_r,
				spacing: stageSpacing_r,
				idxRise: stageIndex_r[15:0],
				idxFall: stageIndex_r[31:16]};
		end
	end

	// pointers; a push into a full fifo is dropped and flagged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			overflow_r <= 1'b0;
		end else begin
			if (flushReq) begin
				wrPtr_r <= rdPtr_r + (AW + 1)'(launch);
			end else if (pushReq & ~fifoFull) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (launch) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			if (pushReq & fifoFull) begin
				overflow_r <= 1'b1;
			end else if (busWrite & (wb_adr_i == `A2Q_OFF_STATUS) & wb_sel_i[0]
				& wb_dat_i[`A2Q_ST_OVF]) begin
				overflow_r <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------
	// train sequencer
	// -------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= A2Q_IDLE;
			job_r <= '0;
			stepsDone_r <= `A2Q_STEP_RST;
			waitCnt_r <= `A2Q_SPACING_MIN;
		end else begin
			case (state_r)
				A2Q_IDLE: begin
					if (launch) begin
						job_r <= fifoMem[rdPtr_r[AW-1:0]];
						stepsDone_r <= `A2Q_STEP_RST;
						// zero spacing would wrap the counter, so treat it as one
						waitCnt_r <= (fifoMem[rdPtr_r[AW-1:0]].spacing == 16'h0000) ?
							`A2Q_SPACING_MIN : fifoMem[rdPtr_r[AW-1:0]].spacing;
						state_r <= A2Q_RUN;
					end
				end
				A2Q_RUN: begin
					if (stepsDone_r == job_r.stepCount) begin
						state_r <= A2Q_IDLE;
					end else if (stepTick) begin
						stepsDone_r <= stepNum;
						waitCnt_r <= (job_r.spacing == 16'h0000) ? `A2Q_SPACING_MIN
							: job_r.spacing;
					end else begin
						waitCnt_r <= waitCnt_r - 16'h0001;
					end
				end
				default: begin
					state_r <= A2Q_IDLE;
				end
			endcase
		end
	end

	// quadrature and index outputs; only step ticks move A and B, index also clears when the train ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			encOut <= '0;
			trainBusy <= 1'b0;
		end else begin
			trainBusy <= (state_r == A2Q_RUN) | launch;
			if (stepTick) begin
				// one bit per step keeps a quarter-period phase shift
				if (job_r.dirCounter == `A2Q_DIR_CW) begin
					encOut.encA <= ~encOut.encB;
					encOut.encB <= encOut.encA;
				end else begin
					encOut.encA <= encOut.encB;
					encOut.encB <= ~encOut.encA;
				end
				if (job_r.crossZero & (stepNum == job_r.idxRise)) begin
					encOut.encIdx <= 1'b1;
				end else if (job_r.crossZero & (stepNum == job_r.idxFall)) begin
					encOut.encIdx <= 1'b0;
				end
			end else if ((state_r == A2Q_RUN) & (stepsDone_r == job_r.stepCount)) begin
				// a fall edge past the last step must not leave index stuck high
				encOut.encIdx <= 1'b0;
			end
		end
	end

endmodule

/* File: dv/a2q_properties.sv */
// checker: port timing of the pulse-train block
// assumes bind onto a2q_top, one clock, async high reset
`timescale 1ns/10ps
module a2q_properties import a2q_pkg::*; (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [7:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // lanes
	input wire logic [31:0] wb_dat_i, // wdata
	input wire logic [31:0] wb_dat_o, // rdata
	input wire logic wb_ack_o, // ack
	input wire a2q_enc_t encOut, // encoder
	input wire logic trainBusy // busy
);
	// ----------------------------------------
	// helper state and assertions
	// ----------------------------------------
	logic setupSeen_r;
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [1:0] ab = {encOut.encA, encOut.encB};
	// set only: a later clear must not mask an early launch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			setupSeen_r <= 1'b0;
		end else if (req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[0]) begin
			setupSeen_r <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ACK_NEXT: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after request");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	AST_NO_SETUP: assert property (!setupSeen_r |-> encOut == 3'h0)
		else $error("output before setup");
	AST_LAUNCH: assert property ($rose(trainBusy) |-> setupSeen_r ##1 trainBusy)
		else $error("bad launch");
	AST_ONE_TOGGLE: assert property (!($changed(encOut.encA) && $changed(encOut.encB)))
		else $error("both phases moved");
	AST_IDLE_STILL: assert property (!trainBusy && !$past(trainBusy) |-> $stable(ab))
		else $error("phase moved while idle");
	// spacing one puts steps on adjacent edges, so only busy around a step is checkable here
	AST_STEP_BUSY: assert property ($changed(ab) |-> trainBusy ##1 trainBusy)
		else $error("step outside a train");
	AST_IDX_STEP: assert property ($rose(encOut.encIdx) |-> $changed(ab) && trainBusy)
		else $error("index off a step");
	cover property ($rose(trainBusy));
	cover property ($rose(encOut.encIdx));
	cover property (req && wb_we_i && wb_adr_i == 8'h14);
endmodule
bind a2q_top a2q_properties chk_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .encOut(encOut),
	.trainBusy(trainBusy));

/* File: dv/a2q_enc_rx.sv */
// partner: encoder input of the downstream drive, decodes position
// assumes encoder lines synchronous to clk
`timescale 1ns/10ps
module a2q_enc_rx import a2q_pkg::*; (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire a2q_enc_t enc, // lines
	output logic [31:0] pos, // position
	output logic [31:0] idxN, // index rises
	output logic [31:0] badN // skipped phases
);
	logic [1:0] prv;
	logic prvIdx;
	logic [1:0] d;
	// phase order 00,10,11,01 counts up; a jump of two is unreadable
	assign d = {enc.encB, enc.encA ^ enc.encB} - {prv[0], prv[1] ^ prv[0]};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prv <= 2'h0;
			prvIdx <= 1'b0;
			pos <= '0;
			idxN <= '0;
			badN <= '0;
		end else begin
			prv <= {enc.encA, enc.encB};
			prvIdx <= enc.encIdx;
			if (d == 2'h1) pos <= pos + 32'h0000_0001;
			if (d == 2'h3) pos <= pos - 32'h0000_0001;
			if (d == 2'h2) badN <= badN + 32'h0000_0001;
			if (enc.encIdx && !prvIdx) idxN <= idxN + 32'h0000_0001;
		end
	end
endmodule

/* File: dv/a2q_top_tb.sv */
// testbench: random and corner jobs through the register bus
// assumes a2q_top with four queue slots and the decoder beside it
`timescale 1ns/10ps
module a2q_top_tb import a2q_pkg::*;;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, busy, dir, crs;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wd = '0, rd, q, pos, idxN, badN, p0;
	logic [15:0] cnt, sp, ri = 16'h0001, fa = 16'h0002;
	logic [1:0] pab = '0;
	a2q_enc_t enc;
	int errors = 0, n_tests = 0, seed = 57, t = 0, lastT, gapExp, gapBad;
	always #2.5 clk = ~clk;
	a2q_top #(.FIFO_DEPTH(4)) dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .encOut(enc), .trainBusy(busy));
	a2q_enc_rx rx_u (.clk(clk), .rst(rst), .enc(enc), .pos(pos), .idxN(idxN), .badN(badN));
	// step gap watch; the first step of a job has no reference
	always @(posedge clk) begin
		t++;
		if ({enc.encA, enc.encB} !== pab) begin
			if (lastT >= 0 && t - lastT != gapExp) gapBad++;
			lastT = t;
		end
		pab = {enc.encA, enc.encB};
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= dat;
		sel <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rd;
		if (n >= 20) begin
			errors++;
			end_sim;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		for (n = 0; n < 3000 && busy !== lvl; n++) @(posedge clk);
		if (n >= 3000) begin
			errors++;
			end_sim;
		end
	endtask
	task automatic job(input logic [15:0] c, input logic [15:0] s, input logic d);
		bus(1'b1, 8'h08, {16'h0000, c});
		bus(1'b1, 8'h0c, {16'h0000, s});
		bus(1'b1, 8'h10, {fa, ri});
		bus(1'b1, 8'h14, {30'h0000_0000, crs, d});
	endtask
	function automatic logic [31:0] delta(input logic [15:0] c, input logic d);
		return d ? -{16'h0000, c} : {16'h0000, c};
	endfunction
	// one job end to end: position and index from the decoder, spacing from the gap watch
	task automatic play(input logic [31:0] ctl);
		logic [31:0] i0, b0;
		p0 = pos;
		i0 = idxN;
		b0 = badN;
		lastT = -1;
		// zero spacing acts as one; steps stand spacing clocks apart
		gapExp = (sp == 0) ? 1 : sp;
		gapBad = 0;
		job(cnt, sp, dir);
		bus(1'b1, 8'h00, ctl);
		wait_busy(1'b0);
		chk(pos - p0, delta(cnt, dir));
		chk(idxN - i0, {31'h0000_0000, crs});
		chk(gapBad, 0);
		chk(badN - b0, 32'h0000_0000);
		bus(1'b0, 8'h18, 32'h0000_0000);
		chk(q, {16'h0000, cnt});
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(enc, 32'h0000_0000);
		bus(1'b0, 8'h00, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		{cnt, sp, dir, crs} = {16'h0005, 16'h0001, 2'b00};
		job(cnt, sp, dir);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk(q, {fa, ri});
		bus(1'b1, 8'h00, 32'h0000_0002);
		repeat (40) @(posedge clk);
		chk(pos, 32'h0000_0000);
		play(32'h0000_0001);
		// the copy pushed by play is still queued; flush it, setup stays on
		bus(1'b1, 8'h00, 32'h0000_0005);
		$display("test setup gate done");
		for (int i = 0; i < 10; i++) begin
			cnt = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0010 : 16'({$random(seed)} % 24);
			sp = (i == 1) ? 16'h0000 : 16'({$random(seed)} % 5);
			dir = 1'($random(seed));
			crs = (cnt > 2) && (i == 1 || 1'($random(seed)));
			ri = (cnt > 2) ? 16'(1 + {$random(seed)} % (cnt - 2)) : 16'h0001;
			fa = (cnt > 2) ? 16'(ri + 1 + {$random(seed)} % (cnt - ri)) : 16'h0002;
			play(32'h0000_0003);
		end
		$display("test random jobs done");
		{cnt, sp, dir, crs} = {16'h0008, 16'h0003, 2'b00};
		job(cnt, sp, dir);
		job(cnt, sp, dir);
		p0 = pos;
		bus(1'b1, 8'h00, 32'h0000_0003);
		bus(1'b0, 8'h04, 32'h0000_0000);
		chk(q[1:0], 32'h0000_0001);
		bus(1'b1, 8'h00, 32'h0000_0003);
		bus(1'b0, 8'h04, 32'h0000_0000);
		chk(q[1:0], 32'h0000_0003);
		// the held start launches the next job after one cycle in idle, and launch keeps busy high over it
		wait_busy(1'b0);
		chk(pos - p0, 32'h0000_0010);
		bus(1'b0, 8'h04, 32'h0000_0000);
		chk(q[2:0], 32'h0000_0004);
		$display("test queued start done");
		for (int i = 0; i < 5; i++) job(16'h0001, 16'h0001, 1'b0);
		bus(1'b0, 8'h04, 32'h0000_0000);
		chk(q[10:0], 32'h0000_0418);
		bus(1'b1, 8'h04, 32'h0000_0010);
		bus(1'b1, 8'h00, 32'h0000_0005);
		bus(1'b0, 8'h04, 32'h0000_0000);
		chk(q[10:0], 32'h0000_0004);
		bus(1'b0, 8'h40, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		$display("test queue limits done");
		// a second reset must drop setup again before any pulse
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(enc, 32'h0000_0000);
		bus(1'b0, 8'h00, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		job(cnt, sp, dir);
		bus(1'b1, 8'h00, 32'h0000_0002);
		repeat (40) @(posedge clk);
		chk(pos, 32'h0000_0000);
		$display("test second reset done");
		end_sim;
	end
endmodule
